// File: shared/dac_cmd_cfg.svh
// Constants for the serial command decoder of the 32-channel DAC bank.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DAC_CMD_CFG_SVH
`define DAC_CMD_CFG_SVH

// --------------------------------------------------------------
// Word layout, MSB first
// --------------------------------------------------------------
`define WORD_BITS 32
`define COUNT_BITS 6
`define CODE_BITS 14
`define NUM_CH 32
`define CMD_MSB 31
`define CMD_LSB 28
`define SEL_MSB 27
`define SEL_LSB 22
`define PAY_MSB 21
`define PAY_LSB 8
`define PAD_MSB 7
`define PAD_LSB 6

// --------------------------------------------------------------
// Command codes
// --------------------------------------------------------------
`define CMD_NOP 4'h0
`define CMD_WRITE_IN 4'h1
`define CMD_LOAD 4'h2
`define CMD_WRITE_UPD 4'h3
`define CMD_SKIP_LOAD 4'h7
`define CMD_GAIN 4'h8
`define CMD_OFFS 4'h9
`define CMD_CFG_WR 4'hc
`define CMD_CFG_RD 4'hd
`define CMD_RESET 4'hf

// --------------------------------------------------------------
// Target select decode
// --------------------------------------------------------------
`define SEL_BANK0 2'h0
`define SEL_BANK1 2'h1
`define SEL_PAIR 2'h2
`define SEL_SPECIAL 2'h3
`define LOW_OFFSET 4'h0
`define LOW_ALL 4'hf
`define SEL_RANGE 6'h30
`define SEL_CONFIG 6'h00

// --------------------------------------------------------------
// Configuration word and reset values
// --------------------------------------------------------------
`define CFG_SINGLE_BIT 12
`define CODE_RESET 14'h0000

`endif

// File: shared/dac_cmd_pkg.sv
// Types shared by the serial capture and the command decoder.
// Assumes dac_cmd_cfg.svh is on the include path.
`include "dac_cmd_cfg.svh"

package dac_cmd_pkg;

  typedef logic [`CODE_BITS-1:0] code_t;
  typedef logic [`NUM_CH-1:0] chan_mask_t;
  typedef logic [3:0] cmd_t;
  typedef logic [5:0] sel_t;
  typedef logic [`WORD_BITS-1:0] word_t;

endpackage

// File: design/serial_word_capture.sv
// Serial capture of 32-bit command words on the falling serial clock edge.
// Assumes serial_clk only runs inside frames and chip_sel_n frames each word.
`include "dac_cmd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module serial_word_capture
  import dac_cmd_pkg::*;
(
  input wire logic serial_clk,
  input wire logic chip_sel_n,
  input wire logic serial_din,
  input wire logic link_rst_n,
  output var word_t word_reg,
  output var logic word_toggle_reg
);

  // ------------------------------------------------------------
  // Bit counter, cleared between frames
  // ------------------------------------------------------------
  logic [`COUNT_BITS-1:0] count_reg;
  logic [`WORD_BITS-2:0] shift_reg;

  // Link reset also clears the count so the first frame after power-up is whole
  always_ff @(negedge serial_clk or posedge chip_sel_n or negedge link_rst_n) begin
    if (chip_sel_n || !link_rst_n) begin
      count_reg <= '0;
    end else if (count_reg != `COUNT_BITS'(`WORD_BITS)) begin
      count_reg <= count_reg + `COUNT_BITS'(1);
    end
  end

  // Bits after the 32nd are ignored
  always_ff @(negedge serial_clk) begin
    if (!chip_sel_n && count_reg < `COUNT_BITS'(`WORD_BITS - 1)) begin
      shift_reg <= {shift_reg[`WORD_BITS-3:0], serial_din};
    end
  end

  // ------------------------------------------------------------
  // Whole word handed over with a toggle
  // ------------------------------------------------------------
  always_ff @(negedge serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      word_reg <= '0;
      word_toggle_reg <= 1'b0;
    end else if (!chip_sel_n && count_reg == `COUNT_BITS'(`WORD_BITS - 1)) begin
      word_reg <= {shift_reg, serial_din};
      word_toggle_reg <= ~word_toggle_reg;
    end
  end

endmodule

`default_nettype wire

// File: design/dac_bank_command_decoder.sv
// Command decoder and register update logic of a 32-channel DAC bank.
// Assumes pins arrive asynchronously; calibration arithmetic sits downstream.
//
// Behaviour
// - A command is exactly one 32-bit word; shorter frames do nothing.
// - Word is command, target select, payload, two pads, six ignored bits.
// - Serial data is captured on the falling serial clock edge.
// - Top select bits pick bank 0, bank 1, both banks, or special targets.
// - Low four bits pick channel n; pair mode drives n and n+16.
// - Pair addressing only for write-update, calibration skip and load.
// - Special low 0000 is the offset channel, 1111 all for load and skip only; others unused.
// - Configuration written by code 1100 with select 000000 only; code 1101 is not decoded.
// - Offset DAC written by code 0011 with select 110000.
// - Offset DAC has its own input and conversion register.
// - All-channel load and skip leave offset DAC registers alone.
// - Load strobe low copies every input register to conversion.
// - Code 0010 select 111111 loads all channels, payload ignored.
// - Code 0111 puts raw payload straight into addressed conversion registers.
// - Calibration skip leaves input registers intact for later reload.
// - Reset pin low clears every channel, offset DAC and configuration register to zero.
// - Code 1111 acts as reset except in chained mode.
// - Code 1001 writes offset registers, 1000 writes gain registers.
// - Code 0001 writes input registers only, outputs wait for a load.
// - Code 0011 on a channel writes input and updates output at once.
// - Gain word zero means unity, else value over two to fourteen.
// - Offset word is signed 14-bit two's complement.
`include "dac_cmd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dac_bank_command_decoder
  import dac_cmd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic serial_clk,
  input wire logic chip_sel_n,
  input wire logic serial_din,
  input wire logic load_strobe_n,
  input wire logic reset_n,
  output var code_t [`NUM_CH-1:0] dac_code_reg,
  output var code_t [`NUM_CH-1:0] gain_word_reg,
  output var code_t [`NUM_CH-1:0] offs_word_reg,
  output var code_t range_code_reg,
  output var code_t config_reg
);

  // ------------------------------------------------------------
  // Serial capture in the link domain
  // ------------------------------------------------------------
  word_t link_word;
  logic link_toggle;

  serial_word_capture u_capture (
    .serial_clk(serial_clk),
    .chip_sel_n(chip_sel_n),
    .serial_din(serial_din),
    .link_rst_n(reset_n),
    .word_reg(link_word),
    .word_toggle_reg(link_toggle)
  );

  // ------------------------------------------------------------
  // Pin and toggle synchronisers
  // ------------------------------------------------------------
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic tog_prev_reg;
  logic tog_edge;
  logic rstn_sync;
  logic hw_load;

  always_ff @(posedge ref_clk) begin
    meta_reg <= {load_strobe_n, reset_n, link_toggle};
    sync_reg <= meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    tog_prev_reg <= sync_reg[0];
  end

  assign tog_edge = sync_reg[0] ^ tog_prev_reg;
  assign rstn_sync = sync_reg[1];
  assign hw_load = ~sync_reg[2];

  // ------------------------------------------------------------
  // Command word held for one decode cycle
  // ------------------------------------------------------------
  word_t cmd_word_reg;
  logic cmd_pulse_reg;

  // Link word is stable for a whole frame after the toggle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmd_word_reg <= '0;
      cmd_pulse_reg <= 1'b0;
    end else begin
      cmd_pulse_reg <= tog_edge;
      if (tog_edge) begin
        cmd_word_reg <= link_word;
      end
    end
  end

  cmd_t cmd_code;
  sel_t target_select;
  code_t payload_word;
  logic pad_bit_hi;
  logic pad_bit_lo;

  assign cmd_code = cmd_word_reg[`CMD_MSB:`CMD_LSB];
  assign target_select = cmd_word_reg[`SEL_MSB:`SEL_LSB];
  assign payload_word = cmd_word_reg[`PAY_MSB:`PAY_LSB];
  // Pads are expected zero and are not decoded
  assign pad_bit_hi = cmd_word_reg[`PAD_MSB];
  assign pad_bit_lo = cmd_word_reg[`PAD_LSB];

  // ------------------------------------------------------------
  // Target decode
  // ------------------------------------------------------------
  function automatic chan_mask_t target_mask(sel_t sel, logic pair_ok, logic all_ok);
    chan_mask_t m;
    m = '0;
    case (sel[5:4])
      `SEL_BANK0: m[{1'b0, sel[3:0]}] = 1'b1;
      `SEL_BANK1: m[{1'b1, sel[3:0]}] = 1'b1;
      `SEL_PAIR: begin
        if (pair_ok) begin
          m[{1'b0, sel[3:0]}] = 1'b1;
          m[{1'b1, sel[3:0]}] = 1'b1;
        end
      end
      default: begin
        if (all_ok && sel[3:0] == `LOW_ALL) begin
          m = '1;
        end
      end
    endcase
    return m;
  endfunction

  function automatic logic is_cmd(cmd_t code, cmd_t want, logic pulse);
    return pulse && code == want;
  endfunction

  chan_mask_t wr_in_mask;
  chan_mask_t wr_upd_mask;
  chan_mask_t load_mask;
  chan_mask_t skip_mask;
  chan_mask_t gain_mask;
  chan_mask_t offs_mask;
  logic range_hit;
  logic range_wr_in;
  logic range_wr_upd;
  logic range_load;
  logic cfg_write;
  logic soft_reset;
  logic rst_all;

  always_comb begin
    wr_in_mask = '0;
    wr_upd_mask = '0;
    load_mask = '0;
    skip_mask = '0;
    gain_mask = '0;
    offs_mask = '0;
    if (is_cmd(cmd_code, `CMD_WRITE_IN, cmd_pulse_reg)) begin
      wr_in_mask = target_mask(target_select, 1'b0, 1'b0);
    end
    if (is_cmd(cmd_code, `CMD_WRITE_UPD, cmd_pulse_reg)) begin
      wr_upd_mask = target_mask(target_select, 1'b1, 1'b0);
    end
    if (is_cmd(cmd_code, `CMD_LOAD, cmd_pulse_reg)) begin
      load_mask = target_mask(target_select, 1'b1, 1'b1);
    end
    if (is_cmd(cmd_code, `CMD_SKIP_LOAD, cmd_pulse_reg)) begin
      skip_mask = target_mask(target_select, 1'b1, 1'b1);
    end
    if (is_cmd(cmd_code, `CMD_GAIN, cmd_pulse_reg)) begin
      gain_mask = target_mask(target_select, 1'b0, 1'b0);
    end
    if (is_cmd(cmd_code, `CMD_OFFS, cmd_pulse_reg)) begin
      offs_mask = target_mask(target_select, 1'b0, 1'b0);
    end
  end

  assign range_hit = target_select == `SEL_RANGE;
  assign range_wr_in = range_hit && is_cmd(cmd_code, `CMD_WRITE_IN, cmd_pulse_reg);
  assign range_wr_upd = range_hit && is_cmd(cmd_code, `CMD_WRITE_UPD, cmd_pulse_reg);
  // Of the load commands, only an explicit offset channel load moves the range DAC
  assign range_load = range_hit && is_cmd(cmd_code, `CMD_LOAD, cmd_pulse_reg);
  assign cfg_write = target_select == `SEL_CONFIG
    && is_cmd(cmd_code, `CMD_CFG_WR, cmd_pulse_reg);
  // Chained mode while the single-device bit is low
  assign soft_reset = is_cmd(cmd_code, `CMD_RESET, cmd_pulse_reg)
    && config_reg[`CFG_SINGLE_BIT];
  assign rst_all = srst || !rstn_sync || soft_reset;

  // ------------------------------------------------------------
  // Channel registers
  // ------------------------------------------------------------
  code_t [`NUM_CH-1:0] input_reg;

  // Gain and offset words are stored raw; the downstream MAC interprets them
  always_ff @(posedge ref_clk) begin
    for (int ch = 0; ch < `NUM_CH; ch++) begin
      if (rst_all) begin
        input_reg[ch] <= `CODE_RESET;
        dac_code_reg[ch] <= `CODE_RESET;
        gain_word_reg[ch] <= `CODE_RESET;
        offs_word_reg[ch] <= `CODE_RESET;
      end else if (cmd_pulse_reg) begin
        if (wr_in_mask[ch]) begin
          input_reg[ch] <= payload_word;
        end
        if (wr_upd_mask[ch]) begin
          input_reg[ch] <= payload_word;
          dac_code_reg[ch] <= payload_word;
        end
        if (load_mask[ch]) begin
          dac_code_reg[ch] <= input_reg[ch];
        end
        if (skip_mask[ch]) begin
          dac_code_reg[ch] <= payload_word;
        end
        if (gain_mask[ch]) begin
          gain_word_reg[ch] <= payload_word;
        end
        if (offs_mask[ch]) begin
          offs_word_reg[ch] <= payload_word;
        end
      end else if (hw_load) begin
        dac_code_reg[ch] <= input_reg[ch];
      end
    end
  end

  // ------------------------------------------------------------
  // Range-setting offset DAC, double buffered
  // ------------------------------------------------------------
  code_t range_in_reg;

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      range_in_reg <= `CODE_RESET;
      range_code_reg <= `CODE_RESET;
    end else if (cmd_pulse_reg) begin
      if (range_wr_in || range_wr_upd) begin
        range_in_reg <= payload_word;
      end
      if (range_wr_upd) begin
        range_code_reg <= payload_word;
      end else if (range_load) begin
        range_code_reg <= range_in_reg;
      end
    end else if (hw_load) begin
      range_code_reg <= range_in_reg;
    end
  end

  // ------------------------------------------------------------
  // Configuration word
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      config_reg <= `CODE_RESET;
    end else if (cfg_write) begin
      config_reg <= payload_word;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_cmd(cmd_t c, sel_t s);
    cmd_pulse_reg && cmd_code == c && target_select == s && !rst_all;
  endsequence

  sequence s_quiet;
    !hw_load && !rst_all;
  endsequence

  word_take_a: assert property (tog_edge |=> cmd_pulse_reg ##1 !cmd_pulse_reg)
    else $error("captured word not decoded once");

  write_input_a: assert property ((s_cmd(`CMD_WRITE_IN, 6'h03) and s_quiet)
    |=> input_reg[3] == $past(payload_word) && $stable(dac_code_reg[3]))
    else $error("input write touched output or missed input");

  pair_update_a: assert property (s_cmd(`CMD_WRITE_UPD, 6'h25)
    |=> dac_code_reg[5] == $past(payload_word)
    && dac_code_reg[21] == $past(payload_word))
    else $error("pair update missed a channel");

  skip_load_a: assert property (s_cmd(`CMD_SKIP_LOAD, 6'h3f)
    |=> dac_code_reg[9] == $past(payload_word)
    && $stable(input_reg[9]) && $stable(range_code_reg))
    else $error("calibration skip load wrong");

  all_load_a: assert property (s_cmd(`CMD_LOAD, 6'h3f)
    |=> dac_code_reg[7] == $past(input_reg[7]) && $stable(range_code_reg))
    else $error("all-channel load wrong");

  hw_load_a: assert property ((hw_load && !cmd_pulse_reg && !rst_all)
    |=> dac_code_reg[31] == $past(input_reg[31])
    && range_code_reg == $past(range_in_reg))
    else $error("hardware load did not copy");

  range_write_a: assert property (s_cmd(`CMD_WRITE_UPD, `SEL_RANGE)
    |=> range_code_reg == $past(payload_word) && range_in_reg == $past(payload_word))
    else $error("offset DAC write wrong");

  pin_reset_a: assert property (!rstn_sync
    |=> dac_code_reg == '0 && input_reg == '0 && config_reg == '0)
    else $error("reset pin did not clear");

  chain_reset_a: assert property ((cmd_pulse_reg && cmd_code == `CMD_RESET
    && !config_reg[`CFG_SINGLE_BIT] && rstn_sync)
    |=> $stable(config_reg) && $stable(gain_word_reg))
    else $error("reset acted in chained mode");

  unused_sel_a: assert property ((cmd_pulse_reg && target_select[5:4] == `SEL_SPECIAL
    && target_select[3:0] != `LOW_OFFSET && target_select[3:0] != `LOW_ALL
    && cmd_code != `CMD_RESET && !hw_load && !rst_all)
    |=> $stable(dac_code_reg) && $stable(input_reg) && $stable(range_code_reg))
    else $error("unused target changed state");

  pair_refuse_a: assert property ((cmd_pulse_reg && cmd_code == `CMD_GAIN
    && target_select[5:4] == `SEL_PAIR && !rst_all) |=> $stable(gain_word_reg))
    else $error("gain write took pair address");

  config_write_a: assert property (s_cmd(`CMD_CFG_WR, `SEL_CONFIG)
    |=> config_reg == $past(payload_word))
    else $error("configuration write missed");

  soft_reset_a: assert property ((cmd_pulse_reg && cmd_code == `CMD_RESET
    && config_reg[`CFG_SINGLE_BIT]) |=> dac_code_reg == '0 && config_reg == '0)
    else $error("software reset did not clear");

endmodule

`default_nettype wire

// File: testbench/serial_host_model.sv
// Host side of the serial link: sends command frames on a 48 ns link clock.
// Assumes the bench calls send_frame; the link clock stands still between frames.
`timescale 1ns/1ns
`default_nettype none

module serial_host_model (
  output var logic serial_clk,
  output var logic chip_sel_n,
  output var logic serial_din
);
  initial begin
    serial_clk = 1'b1;
    chip_sel_n = 1'b1;
    serial_din = 1'b0;
  end

  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  task automatic send_frame(input logic [31:0] w, input int nbits);
    #7;
    chip_sel_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_din = w[31-i];
      #12 serial_clk = 1'b0;
      #24 serial_clk = 1'b1;
      #12;
    end
    chip_sel_n = 1'b1;
    // Released line shows the inverse of the last bit
    serial_din = ~serial_din;
  endtask
endmodule

`default_nettype wire

// File: testbench/dac_bank_command_decoder_tb.sv
// Self-checking bench of the serial command decoder.
// Assumes the host model drives the link; the bench drives pins at the falling edge.
`include "dac_cmd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dac_bank_command_decoder_tb;
  import dac_cmd_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic load_strobe_n = 1'b1;
  logic reset_n = 1'b1;
  logic serial_clk;
  logic chip_sel_n;
  logic serial_din;
  code_t [`NUM_CH-1:0] dac_code_reg;
  code_t [`NUM_CH-1:0] gain_word_reg;
  code_t [`NUM_CH-1:0] offs_word_reg;
  code_t [`NUM_CH-1:0] snap_dac;
  code_t range_code_reg;
  code_t config_reg;
  int error_cnt = 0;
  int checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  serial_host_model host (
    .serial_clk(serial_clk),
    .chip_sel_n(chip_sel_n),
    .serial_din(serial_din)
  );

  dac_bank_command_decoder dut (
    .ref_clk(ref_clk),
    .srst(srst),
    .serial_clk(serial_clk),
    .chip_sel_n(chip_sel_n),
    .serial_din(serial_din),
    .load_strobe_n(load_strobe_n),
    .reset_n(reset_n),
    .dac_code_reg(dac_code_reg),
    .gain_word_reg(gain_word_reg),
    .offs_word_reg(offs_word_reg),
    .range_code_reg(range_code_reg),
    .config_reg(config_reg)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input code_t got, input code_t exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmd(input cmd_t c, input sel_t s, input code_t p, input int nbits = 32);
    host.send_frame({c, s, p, 2'b00, 6'h15}, nbits);
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic check_cleared();
    for (int i = 0; i < `NUM_CH; i++) begin
      check(dac_code_reg[i], 14'h0000, "dac clear");
      check(gain_word_reg[i], 14'h0000, "gain clear");
      check(offs_word_reg[i], 14'h0000, "offs clear");
    end
    check(range_code_reg, 14'h0000, "range clear");
    check(config_reg, 14'h0000, "config clear");
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write_load();
    cmd(4'h1, 6'h03, 14'h1234);
    check(dac_code_reg[3], 14'h0000, "write input moved output");
    cmd(4'h2, 6'h03, 14'h3fff);
    check(dac_code_reg[3], 14'h1234, "single load");
  endtask

  task automatic t_pair_bank();
    cmd(4'h3, 6'h25, 14'h0555);
    check(dac_code_reg[5], 14'h0555, "pair low");
    check(dac_code_reg[21], 14'h0555, "pair high");
    cmd(4'h3, 6'h12, 14'h2222);
    check(dac_code_reg[18], 14'h2222, "bank one");
    check(dac_code_reg[2], 14'h0000, "bank one leak");
  endtask

  task automatic t_range();
    cmd(4'h3, 6'h30, 14'h1000);
    check(range_code_reg, 14'h1000, "range write");
    check(dac_code_reg[0], 14'h0000, "range hit channel");
    cmd(4'h7, 6'h3f, 14'h0abc);
    check(dac_code_reg[0], 14'h0abc, "skip all low");
    check(dac_code_reg[31], 14'h0abc, "skip all high");
    check(range_code_reg, 14'h1000, "skip all range");
    cmd(4'h1, 6'h30, 14'h2000);
    check(range_code_reg, 14'h1000, "range input only");
    cmd(4'h2, 6'h3f, 14'h2aaa);
    check(dac_code_reg[3], 14'h1234, "load all ch3");
    check(dac_code_reg[21], 14'h0555, "load all ch21");
    check(dac_code_reg[0], 14'h0000, "load all ch0");
    check(range_code_reg, 14'h1000, "load all range");
  endtask

  task automatic t_skip_hw();
    cmd(4'h7, 6'h03, 14'h0777);
    check(dac_code_reg[3], 14'h0777, "skip single");
    load_strobe_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    load_strobe_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(dac_code_reg[3], 14'h1234, "strobe reload");
    check(dac_code_reg[18], 14'h2222, "strobe ch18");
    check(range_code_reg, 14'h2000, "strobe range");
  endtask

  task automatic t_cal_regs();
    cmd(4'h8, 6'h07, 14'h2000);
    check(gain_word_reg[7], 14'h2000, "gain write");
    cmd(4'h9, 6'h11, 14'h3fff);
    check(offs_word_reg[17], 14'h3fff, "offs write");
    cmd(4'h8, 6'h21, 14'h0001);
    check(gain_word_reg[1], 14'h0000, "gain pair low");
    check(gain_word_reg[17], 14'h0000, "gain pair high");
  endtask

  task automatic t_unused();
    snap_dac = dac_code_reg;
    cmd(4'h3, 6'h35, 14'h0999);
    cmd(4'hc, 6'h01, 14'h1fff);
    cmd(4'h3, 6'h09, 14'h0abc, 31);
    for (int i = 0; i < `NUM_CH; i++) begin
      check(dac_code_reg[i], snap_dac[i], "unused moved output");
    end
    check(config_reg, 14'h0000, "config bad select");
  endtask

  task automatic t_soft_reset();
    cmd(4'hc, 6'h00, 14'h0200);
    check(config_reg, 14'h0200, "config write");
    cmd(4'hf, 6'h00, 14'h0000);
    check(dac_code_reg[3], 14'h1234, "reset in chained mode");
    cmd(4'hc, 6'h00, 14'h1000);
    cmd(4'hf, 6'h00, 14'h0000);
    check_cleared();
  endtask

  task automatic t_hw_reset();
    cmd(4'h3, 6'h30, 14'h2000);
    cmd(4'h9, 6'h07, 14'h0100);
    reset_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    check_cleared();
    cmd(4'h3, 6'h30, 14'h2000);
    check(range_code_reg, 14'h2000, "range rewrite");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    @(negedge ref_clk);
    // Link side has no other power-up clear
    reset_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    reset_n = 1'b1;
    @(negedge ref_clk);
    check_cleared();
    t_write_load();
    t_pair_bank();
    t_range();
    t_skip_hw();
    t_cal_regs();
    t_unused();
    t_soft_reset();
    t_hw_reset();
    wrap_up();
  end

  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end
endmodule

`default_nettype wire
